//--- ppg_defines.svh
/*
 * Offsets, field positions, reset values and fixed pin indices of the
 * port glue block. Assumes inclusion by bare name from the design files.
 */
`ifndef PPG_DEFINES_SVH
`define PPG_DEFINES_SVH

// ********
// Register byte offsets
// ********
`define PPG_GCTRL_OFF   8'h00
`define PPG_GMODE_OFF   8'h04
`define PPG_GPIN_OFF    8'h08
`define PPG_GSTAT_OFF   8'h0C
`define PPG_PCTRL_OFF   4'h0
`define PPG_PSTAT_OFF   4'h4
`define PPG_PCNT_OFF    4'h8

// ********
// Global control fields
// ********
`define PPG_G_UMODE     1:0
`define PPG_G_REFO      2
`define PPG_G_REFI      3
`define PPG_G_MEIS      4
`define PPG_G_MEI       5
`define PPG_G_UPD       6

// ********
// Port control fields
// ********
`define PPG_P_LBSEL     2:0
`define PPG_P_LOOP_TIMING_ENABLE     3
`define PPG_P_LAIS      5:4
`define PPG_P_UPD       6
`define PPG_P_MEI       7
`define PPG_P_FOLLOW    8
`define PPG_P_EN        9
`define PPG_P_LIU       10
`define PPG_P_DS3       11
`define PPG_P_LLBAIS    12
`define PPG_P_PLBOFF    13
`define PPG_P_PLBAIS    14
`define PPG_P_BMEI      15
`define PPG_P_ALA       19:16
`define PPG_P_ALB       23:20

// ********
// Reset values, limits and fixed pins
// ********
`define PPG_GCTRL_RST   32'h0000_0000
`define PPG_GMODE_RST   16'h0000
`define PPG_PCTRL_RST   32'h0000_0200
`define PPG_CNT_MAX     32'hFFFF_FFFF
`define PPG_PIN_REFO    1
`define PPG_PIN_REFI    3
`define PPG_PIN_MEI     5
`define PPG_PIN_UPD     7

`endif

//--- ppg_pkg.sv
/*
 * Types of the port glue block: line signal triplet and alarm bundle.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ppg_pkg;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic clk;
        logic pos;
        logic neg;
    } ppg_line_type;

    typedef struct packed {
        logic los;
        logic oof;
        logic lof;
        logic ais;
        logic rai;
        logic idle;
    } ppg_alarm_type;

endpackage : ppg_pkg

//--- ppg_top.sv
/*
 * Port glue for a four-port line transceiver: general pins, counter
 * update-clear control, error insert source and loopback multiplexers,
 * with registers on an AHB-Lite slave.
 * Assumes one clock hclk; line, framer and alarm inputs other than the
 * receive line pins and the general pins are already on hclk.
 */
// Local design decisions: the placing of the registers and register access over AHB-Lite.
`include "ppg_defines.svh"

// Operation
// - Eight general pins, two per port
// - Mode field: input, alarm, low, high
// - Disabled port alarm mode drives low
// - Unselected pin sourced signals read low
// - Fixed pins for the four global signals
// - Four-bit alarm select per pin
// - Counters hold a second, saturate
// - Nonzero, zero-to-one and event flags
// - Update copies count, clears, keeps coincident
// - Update strobe source selectable
// - Status follows strobe level shortly after
// - Unfollowing port masked from global status
// - Error insert source: own or external
// - Loopback select decode
// - Loop timing blocks analog loopback
// - Analog loop routes line or pin signals
// - Line loop resamples on receive clock
// - Optional receive AIS in line loop
// - Payload loop, frame start ignored
// - Payload loop pin forcing and AIS
// - Diagnostic loop returns pre-encode data
// - Automatic line AIS during diagnostic loop
// - One-second edge updates in mode 1X
module ppg_top (
    // Clock and reset
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    // AHB-Lite slave
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic [31:0]                 hrdata,
    output logic                        hresp,
    // General pins
    input  wire logic [7:0]             gpio_in,
    output logic [7:0]                  gpio_out,
    output logic [7:0]                  gpio_oe_n,
    // Global core signals
    input  wire logic                   ref_8khz_out,
    input  wire logic                   one_second_ref,
    output logic                        ref_8khz_in,
    output logic                        manual_error_insert,
    output logic                        perf_update_status,
    // Per-port monitoring
    input  wire ppg_pkg::ppg_alarm_type [3:0] alarm,
    input  wire logic [3:0]             count_event,
    output logic [3:0]                  perf_update_strobe,
    output logic [3:0]                  block_error_insert,
    // Per-port line side
    input  wire ppg_pkg::ppg_line_type [3:0] tx_encoded,
    input  wire ppg_pkg::ppg_line_type [3:0] rx_line_pins,
    input  wire ppg_pkg::ppg_line_type [3:0] rx_liu,
    input  wire ppg_pkg::ppg_line_type [3:0] ais_ds3_line,
    input  wire ppg_pkg::ppg_line_type [3:0] ais_ones_line,
    output ppg_pkg::ppg_line_type [3:0] tx_line,
    output ppg_pkg::ppg_line_type [3:0] rx_to_decoder,
    // Per-port framer side
    input  wire logic [3:0]             tx_pre_encode,
    input  wire logic [3:0]             rx_decoded,
    input  wire logic [3:0]             rx_payload,
    input  wire logic [3:0]             tx_serial_in,
    input  wire logic [3:0]             tx_frame_start_in,
    input  wire logic [3:0]             tx_den_core,
    input  wire logic [3:0]             tx_sof_core,
    input  wire logic [3:0]             rx_serial_core,
    output logic [3:0]                  rx_framer_data,
    output logic [3:0]                  tx_payload,
    output logic [3:0]                  tx_frame_start_core,
    output logic [3:0]                  tx_data_enable_out,
    output logic [3:0]                  tx_frame_start_out,
    output logic [3:0]                  rx_serial_out
);
    import ppg_pkg::*;

    // ********
    // Registers and synchronisers
    // ********
    logic [31:0]        gctrl;
    logic [15:0]        pin_mode_bits;
    logic [31:0]        pctrl [4];
    logic [31:0]        count [4];
    logic [31:0]        count_read [4];
    logic [3:0]         zero_to_one;
    logic [3:0]         event_seen;
    logic [3:0]         port_status;
    logic               global_latch;
    logic               global_prev;
    logic [7:0]         gpio_s1;
    logic [7:0]         gpio_s2;
    ppg_line_type [3:0] rxp_s1;
    ppg_line_type [3:0] rxp_s2;
    logic [3:0]         rx_clk_prev;
    logic [3:0]         resamp_pos;
    logic [3:0]         resamp_neg;
    logic               wr_pend;
    logic [7:0]         wr_addr;

    // ********
    // Bus decode
    // ********
    wire        addr_take = hsel & htrans[1] & hready;
    wire [7:0]  a8        = haddr[7:0];
    wire        a_port    = (haddr[31:8] == 24'h00_0000) & (a8[7:4] >= 4'h1) & (a8[7:4] <= 4'h4);
    wire [1:0]  a_idx     = 2'(a8[7:4] - 4'h1);
    wire [1:0]  w_idx     = 2'(wr_addr[7:4] - 4'h1);
    wire        w_port    = (wr_addr[7:4] >= 4'h1) & (wr_addr[7:4] <= 4'h4);
    wire        w_gctrl   = wr_pend & (wr_addr == `PPG_GCTRL_OFF);
    wire        w_gmode   = wr_pend & (wr_addr == `PPG_GMODE_OFF);
    wire        w_gstat   = wr_pend & (wr_addr == `PPG_GSTAT_OFF);

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ********
    // Global strobe and pin-sourced signals
    // ********
    wire [1:0] umode   = gctrl[`PPG_G_UMODE];
    wire       pin_upd = (umode == 2'b01) & gpio_s2[`PPG_PIN_UPD];
    wire       glob_strobe = (umode == 2'b00) ? gctrl[`PPG_G_UPD] :
                             (umode == 2'b01) ? pin_upd : one_second_ref;
    wire       pin_mei = gctrl[`PPG_G_MEIS] & gpio_s2[`PPG_PIN_MEI];

    assign ref_8khz_in         = gctrl[`PPG_G_REFI] & gpio_s2[`PPG_PIN_REFI];
    assign manual_error_insert = pin_mei;

    // Only ports that follow the global strobe reach the global status
    logic [3:0] follow_mask;
    assign perf_update_status = |(port_status & follow_mask);

    // ********
    // Alarm selection
    // ********
    function automatic logic alarm_pick(input logic [3:0] code, input ppg_alarm_type al);
        logic r;
        r = 1'b0;
        case (code)
            4'h0: r = al.los;
            4'h1: r = al.oof;
            4'h2: r = al.lof;
            4'h3: r = al.ais;
            4'h4: r = al.rai;
            4'h5: r = al.idle;
            4'hB, 4'hD: r = al.los | al.lof | al.ais;
            4'hE: r = al.rai | al.idle;
            4'hF: r = |al;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : alarm_pick

    // ********
    // General pin drivers
    // ********
    logic [7:0] next_gpio_out;
    logic [7:0] next_gpio_oe_n;
    for (genvar i = 0; i < 8; i++) begin : g_pin
        localparam int P = i / 2;
        wire [1:0] pin_mode_field = pin_mode_bits[2*i+1:2*i];
        wire [3:0] sel = (i % 2 == 0) ? pctrl[P][`PPG_P_ALA] : pctrl[P][`PPG_P_ALB];
        wire       g_out = (i == `PPG_PIN_REFO) & gctrl[`PPG_G_REFO];
        wire       g_in  = ((i == `PPG_PIN_REFI) & gctrl[`PPG_G_REFI]) |
                           ((i == `PPG_PIN_MEI) & gctrl[`PPG_G_MEIS]) |
                           ((i == `PPG_PIN_UPD) & (umode == 2'b01));
        // Disabled ports still serve as plain or global pins
        wire       al_val = pctrl[P][`PPG_P_EN] & alarm_pick(sel, alarm[P]);
        assign next_gpio_oe_n[i] = g_out ? 1'b0 : g_in ? 1'b1 :
                                   (pin_mode_field == 2'b00);
        assign next_gpio_out[i]  = g_out ? ref_8khz_out : g_in ? 1'b0 :
                                   (pin_mode_field == 2'b01) ? al_val :
                                   (pin_mode_field == 2'b11);
    end

    // ********
    // Per-port update, counters and loopback
    // ********
    logic [31:0]  port_rd [4];
    logic [3:0]   upd_pulse;
    logic [3:0]   port_strobe;
    ppg_line_type [3:0] next_tx_line;
    ppg_line_type [3:0] next_rx_dec;
    logic [3:0]   next_rx_framer;
    logic [3:0]   next_tx_payload;
    logic [3:0]   next_tsof_core;
    logic [3:0]   next_tden;
    logic [3:0]   next_tsof;
    logic [3:0]   next_rser;

    for (genvar p = 0; p < 4; p++) begin : g_port
        wire [31:0] pc    = pctrl[p];
        wire [2:0]  lbsel = pc[`PPG_P_LBSEL];
        // Loopback decode; loop timing suppresses the analog path
        wire analog_loop     = (lbsel == 3'b001) & ~pc[`PPG_P_LOOP_TIMING_ENABLE];
        wire line_loop       = (lbsel[1:0] == 2'b10);
        wire payload_loop    = (lbsel == 3'b011);
        wire diagnostic_loop = lbsel[2];
        wire [1:0] lais      = pc[`PPG_P_LAIS];
        wire line_ais        = ((lais == 2'b00) & diagnostic_loop) |
                               (lais == 2'b01) | (lais == 2'b10);
        wire use_ds3_ais     = pc[`PPG_P_DS3] & (lais != 2'b01);
        // Receive source: looped transmit, LINE_INTERFACE_UNIT or synchronised pins
        wire ppg_line_type rx_src = analog_loop ?
                                    (pc[`PPG_P_LIU] ? tx_line[p] : tx_encoded[p]) :
                                    (pc[`PPG_P_LIU] ? rx_liu[p] : rxp_s2[p]);
        wire rx_rise = rx_src.clk & ~rx_clk_prev[p];
        wire rx_ais  = (line_loop & pc[`PPG_P_LLBAIS]) |
                       (payload_loop & pc[`PPG_P_PLBAIS]);

        assign follow_mask[p] = pc[`PPG_P_FOLLOW];
        assign port_strobe[p] = pc[`PPG_P_FOLLOW] ? glob_strobe : pc[`PPG_P_UPD];
        assign upd_pulse[p]   = port_strobe[p] & ~port_status[p];
        assign block_error_insert[p] = gctrl[`PPG_G_MEIS] ?
                                       (pc[`PPG_P_MEI] | gctrl[`PPG_G_MEI] | pin_mei) :
                                       pc[`PPG_P_BMEI];

        // Line loop ignores transmit AIS; resampled receive data goes out
        assign next_tx_line[p] = line_loop ?
                                 '{clk: rx_src.clk, pos: resamp_pos[p], neg: resamp_neg[p]} :
                                 line_ais ? (use_ds3_ais ? ais_ds3_line[p] : ais_ones_line[p]) :
                                 tx_encoded[p];
        assign next_rx_dec[p]     = rx_src;
        assign next_rx_framer[p]  = diagnostic_loop ? tx_pre_encode[p] : rx_decoded[p];
        assign next_tx_payload[p] = payload_loop ? rx_payload[p] : tx_serial_in[p];
        assign next_tsof_core[p]  = ~payload_loop & tx_frame_start_in[p];
        assign next_tden[p] = ~(payload_loop & pc[`PPG_P_PLBOFF]) & tx_den_core[p];
        assign next_tsof[p] = ~(payload_loop & pc[`PPG_P_PLBOFF]) & tx_sof_core[p];
        assign next_rser[p] = rx_ais | rx_serial_core[p];

        assign port_rd[p] = (a8[3:0] == `PPG_PCTRL_OFF) ? pc :
                            (a8[3:0] == `PPG_PSTAT_OFF) ?
                            {28'h000_0000, port_status[p], event_seen[p],
                             zero_to_one[p], count[p] != 32'h0000_0000} :
                            (a8[3:0] == `PPG_PCNT_OFF) ? count_read[p] : 32'h0000_0000;

        // Line loop resampling on the receive clock edge
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                rx_clk_prev[p] <= 1'b0;
                resamp_pos[p]  <= 1'b0;
                resamp_neg[p]  <= 1'b0;
            end else begin
                rx_clk_prev[p] <= rx_src.clk;
                if (rx_rise) begin
                    resamp_pos[p] <= rx_src.pos;
                    resamp_neg[p] <= rx_src.neg;
                end
            end
        end

        // Saturating counter with update-clear; coincident event counts as one
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                count[p]      <= 32'h0000_0000;
                count_read[p] <= 32'h0000_0000;
            end else if (upd_pulse[p]) begin
                count_read[p] <= count[p];
                count[p]      <= {31'h0000_0000, count_event[p]};
            end else if (count_event[p] && count[p] != `PPG_CNT_MAX) begin
                count[p] <= count[p] + 32'h0000_0001;
            end
        end

        // Sticky flags: a new event beats a same-cycle clear
        wire clr = wr_pend & w_port & (w_idx == 2'(p)) & (wr_addr[3:0] == `PPG_PSTAT_OFF);
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                zero_to_one[p] <= 1'b0;
                event_seen[p]  <= 1'b0;
                port_status[p] <= 1'b0;
            end else begin
                zero_to_one[p] <= (count_event[p] & (upd_pulse[p] | count[p] == 32'h0000_0000)) |
                                  (zero_to_one[p] & ~(clr & hwdata[1]));
                event_seen[p]  <= count_event[p] | (event_seen[p] & ~(clr & hwdata[2]));
                port_status[p] <= port_strobe[p];
            end
        end
    end

    assign perf_update_strobe = upd_pulse;

    // ********
    // Register writes (data phase)
    // ********
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= addr_take & hwrite & (haddr[31:8] == 24'h00_0000);
            wr_addr <= a8;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gctrl         <= `PPG_GCTRL_RST;
            pin_mode_bits <= `PPG_GMODE_RST;
            for (int k = 0; k < 4; k++) pctrl[k] <= `PPG_PCTRL_RST;
        end else begin
            if (w_gctrl) gctrl <= {25'h000_0000, hwdata[6:0]};
            if (w_gmode) pin_mode_bits <= hwdata[15:0];
            if (wr_pend && w_port && wr_addr[3:0] == `PPG_PCTRL_OFF)
                pctrl[w_idx] <= {8'h00, hwdata[23:0]};
        end
    end

    // Global latched update status, rising edge sets, write one clears
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            global_prev  <= 1'b0;
            global_latch <= 1'b0;
        end else begin
            global_prev  <= perf_update_status;
            global_latch <= (perf_update_status & ~global_prev) |
                            (global_latch & ~(w_gstat & hwdata[1]));
        end
    end

    // ********
    // Read data, registered in the address phase
    // ********
    wire [31:0] rd_word = a_port ? port_rd[a_idx] :
                          (a8 == `PPG_GCTRL_OFF) ? gctrl :
                          (a8 == `PPG_GMODE_OFF) ? {16'h0000, pin_mode_bits} :
                          (a8 == `PPG_GPIN_OFF)  ? {24'h00_0000, gpio_s2} :
                          (a8 == `PPG_GSTAT_OFF) ?
                          {24'h00_0000, port_status, 2'b00, global_latch, perf_update_status} :
                          32'h0000_0000;
    wire        rd_ok   = haddr[31:8] == 24'h00_0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) hrdata <= 32'h0000_0000;
        else if (addr_take && !hwrite) hrdata <= rd_ok ? rd_word : 32'h0000_0000;
    end

    // ********
    // Pin synchronisers and registered outputs
    // ********
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gpio_s1 <= 8'h00;
            gpio_s2 <= 8'h00;
            rxp_s1  <= '0;
            rxp_s2  <= '0;
        end else begin
            gpio_s1 <= gpio_in;
            gpio_s2 <= gpio_s1;
            rxp_s1  <= rx_line_pins;
            rxp_s2  <= rxp_s1;
        end
    end

    // One cycle of latency on every pin, line and framer output keeps those outputs glitch free
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gpio_out            <= 8'h00;
            gpio_oe_n           <= 8'hFF;
            tx_line             <= '0;
            rx_to_decoder       <= '0;
            rx_framer_data      <= 4'h0;
            tx_payload          <= 4'h0;
            tx_frame_start_core <= 4'h0;
            tx_data_enable_out  <= 4'h0;
            tx_frame_start_out  <= 4'h0;
            rx_serial_out       <= 4'h0;
        end else begin
            gpio_out            <= next_gpio_out;
            gpio_oe_n           <= next_gpio_oe_n;
            tx_line             <= next_tx_line;
            rx_to_decoder       <= next_rx_dec;
            rx_framer_data      <= next_rx_framer;
            tx_payload          <= next_tx_payload;
            tx_frame_start_core <= next_tsof_core;
            tx_data_enable_out  <= next_tden;
            tx_frame_start_out  <= next_tsof;
            rx_serial_out       <= next_rser;
        end
    end

endmodule : ppg_top

//--- ppg_top_asserts.sv
/* Port checker for ppg_top, bound after the module.
   Assumes one clock hclk and asynchronous active-low hresetn. */
module ppg_top_asserts (
    // Clock, reset and bus
    input wire logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
    input wire logic [1:0]  htrans,
    input wire logic [31:0] hrdata,
    // Pins and core signals
    input wire logic [7:0]  gpio_in, gpio_oe_n,
    input wire logic        ref_8khz_in, manual_error_insert, perf_update_status,
    input wire logic [3:0]  perf_update_strobe, block_error_insert
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Read address phase and any update pulse
    wire rd_req = hsel && htrans[1] && hready && !hwrite;
    wire any_pulse = |perf_update_strobe;
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus stall or error");
    a_rdata_holds: assert property (!rd_req |=> $stable(hrdata)) else $error("rdata moved");
    a_pulse_single: assert property ((perf_update_strobe & $past(perf_update_strobe)) == 4'h0)
        else $error("update pulse too long");
    a_ref_in_value: assert property (ref_8khz_in |-> $past(gpio_in[3], 2))
        else $error("ref in without pin");
    a_ref_in_dir: assert property (ref_8khz_in |=> gpio_oe_n[3]) else $error("ref pin driven");
    a_err_in_value: assert property (manual_error_insert |-> $past(gpio_in[5], 2))
        else $error("insert without pin");
    a_err_in_dir: assert property (manual_error_insert |=> gpio_oe_n[5]) else $error("pin driven");
    a_err_in_fans: assert property (manual_error_insert |-> block_error_insert == 4'hF)
        else $error("insert not fanned out");
    a_status_rise: assert property ($rose(perf_update_status) |-> $past(any_pulse))
        else $error("status without pulse");
    c_read: cover property (rd_req);
    c_status: cover property ($rose(perf_update_status));
    c_err_in: cover property (manual_error_insert);
endmodule : ppg_top_asserts

bind ppg_top ppg_top_asserts ppg_top_asserts_i (.*);

//--- ppg_far_model.sv
/* Far side: alarms, count events and receive line signals.
   Assumes the bench steers alarms and events on hclk. */
module ppg_far_model (
    // Clock and steering
    input wire logic                        hclk,
    input wire logic                        ev_on,
    input wire ppg_pkg::ppg_alarm_type      al_set,
    // Toward the block
    output ppg_pkg::ppg_alarm_type [3:0]    alarm,
    output logic [3:0]                      count_event,
    output ppg_pkg::ppg_line_type [3:0]     rx_liu,
    output ppg_pkg::ppg_line_type [3:0]     rx_line_pins
);
    timeunit 1ns;
    timeprecision 1ns;
    import ppg_pkg::*;
    logic rx_clk = 1'b0;
    // A live line clock never stops
    always @(posedge hclk) rx_clk <= ~rx_clk;
    // Events on port 0 only, so other counters stay quiet
    assign alarm = {4{al_set}};
    assign count_event = {3'b000, ev_on};
    // Pin levels differ from the first transmit side levels so a loop shows
    assign rx_liu = {4{rx_clk, 2'b10}};
    assign rx_line_pins = {4{rx_clk, 2'b01}};
endmodule : ppg_far_model

//--- ppg_top_bench.sv
/* Bench for ppg_top: AHB-Lite master tasks and call sequences.
   Assumes the far model and the bound checker. */
module ppg_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import ppg_pkg::*;
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ev_on = 1'b0;
    logic        one_second_ref = 1'b0;
    logic        hreadyout, hresp, ref_8khz_in, manual_error_insert, perf_update_status;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd = 32'h0;
    logic [7:0]  gpio_in = 8'h00, gpio_out, gpio_oe_n;
    logic [19:0] fr = 20'h10101;
    logic [3:0]  count_event, perf_update_strobe, block_error_insert, rx_framer_data;
    logic [3:0]  tx_payload, tx_frame_start_core, tx_data_enable_out, rx_serial_out;
    logic [4:0]  v;
    ppg_alarm_type       al_set = 6'h00;
    ppg_alarm_type [3:0] alarm;
    ppg_line_type [3:0]  tx_encoded = {4{3'b110}}, ais_ones_line = {4{3'b101}};
    ppg_line_type [3:0]  ais_ds3_line = {4{3'b010}}, rx_liu, rx_line_pins, tx_line, rx_to_decoder;
    int err_total = 0, comparisons = 0, c, b, m, n;
    wire [3:0] tx_pre_encode = fr[3:0], rx_decoded = fr[7:4], rx_payload = fr[11:8];
    wire [3:0] tx_serial_in = fr[15:12], tx_frame_start_in = fr[19:16];
    ppg_top ppg_top_i (.*, .hready(hreadyout), .hsize(3'b010), .tx_den_core(4'hF),
        .tx_sof_core(4'h0), .rx_serial_core(4'h0), .ref_8khz_out(1'b0),
        .tx_frame_start_out());
    ppg_far_model ppg_far_model_i (.*);
    always #20 hclk = ~hclk;
    // ****************************************
    // Tasks
    // ****************************************
    task automatic finish_test;
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test
    // Single transfer, then one idle cycle so a read never follows a write directly
    task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
        int k;
        k = 0;
        hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= a;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 50);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 50);
        q = hrdata;
        if (k >= 50) begin err_total++; finish_test(); end
        @(posedge hclk);
    endtask : bus
    task automatic wr(input logic [31:0] a, d);
        bus(1'b1, a, d, rd);
    endtask : wr
    task automatic rd_chk(input logic [31:0] a, e);
        bus(1'b0, a, 32'h0, rd);
        `CHK(rd, e)
    endtask : rd_chk
    task automatic wait_st(input logic e);
        for (n = 0; n < 40 && perf_update_status !== e; n++) @(posedge hclk);
        `CHK(perf_update_status, e)
        if (n == 40) finish_test();
    endtask : wait_st
    // Alarm mask per select code: los oof lof ais rai idle
    function automatic logic [5:0] amask(input logic [3:0] k);
        case (k)
            0, 1, 2, 3, 4, 5: amask = 6'h20 >> k;
            11, 13: amask = 6'h2C;
            14: amask = 6'h03;
            15: amask = 6'h3F;
            default: amask = 6'h00;
        endcase
    endfunction : amask
    initial begin #4000000; err_total++; finish_test(); end
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(32'h10, 32'h200);
        wr(32'h100, 32'hFFFF_FFFF);
        rd_chk(32'h100, 32'h0);
        wr(32'h04, 32'h1);
        for (c = 0; c < 16; c++) begin
            wr(32'h10, 32'h200 | (c << 16));
            for (b = 0; b < 6; b++) begin
                al_set <= 6'h20 >> b;
                repeat (3) @(posedge hclk);
                `CHK(gpio_out[0], |(amask(c) & (6'h20 >> b)))
            end
        end
        al_set <= 6'h3F;
        wr(32'h10, 32'h000F_0000);
        for (m = 0; m < 4; m++) begin
            wr(32'h04, m);
            @(posedge hclk);
            `CHK({gpio_oe_n[0], gpio_out[0]}, {m == 0, m == 3})
        end
        wr(32'h04, 32'h0);
        repeat (2) begin
            for (v = 0; v < 16; v++) begin
                wr(32'h10, 32'h7200 | v);
                @(posedge hclk);
                `CHK(rx_framer_data[0], v[2] ? tx_pre_encode[0] : rx_decoded[0])
                `CHK(tx_payload[0], (v[2:0] == 3) ? rx_payload[0] : tx_serial_in[0])
                `CHK(tx_frame_start_core[0], (v[2:0] != 3) & tx_frame_start_in[0])
                `CHK(rx_serial_out[0], (v[1:0] == 2) | (v[2:0] == 3))
                `CHK(tx_data_enable_out[0], v[2:0] != 3)
                `CHK(rx_to_decoder[0][1:0], (v == 1) ? tx_encoded[0][1:0] : 2'b01)
                if (v[1:0] != 2) `CHK(tx_line[0][1:0], v[2] ? ais_ones_line[0][1:0] : tx_encoded[0][1:0])
            end
            fr <= ~fr;
            tx_encoded <= ~tx_encoded;
            ais_ones_line <= ~ais_ones_line;
            ais_ds3_line <= ~ais_ds3_line;
        end
        wr(32'h10, 32'h200);
        ev_on <= 1'b1;
        repeat (5) @(posedge hclk);
        ev_on <= 1'b0;
        rd_chk(32'h14, 32'h7);
        wr(32'h10, 32'h240);
        n = 0;
        do begin bus(1'b0, 32'h14, 32'h0, rd); n++; end while (rd[3] !== 1'b1 && n < 20);
        `CHK(rd[3], 1'b1)
        if (rd[3] !== 1'b1) finish_test();
        wr(32'h10, 32'h200);
        rd_chk(32'h18, 32'h5);
        ev_on <= 1'b1;
        repeat (3) @(posedge hclk);
        ev_on <= 1'b0;
        wr(32'h00, 32'h1);
        wr(32'h10, 32'h300);
        gpio_in <= 8'h80;
        wait_st(1'b1);
        gpio_in <= 8'h00;
        wait_st(1'b0);
        rd_chk(32'h18, 32'h3);
        wr(32'h00, 32'h2);
        one_second_ref <= 1'b1;
        wait_st(1'b1);
        one_second_ref <= 1'b0;
        wait_st(1'b0);
        gpio_in <= 8'h28;
        wr(32'h00, 32'h18);
        repeat (3) @(posedge hclk);
        `CHK({ref_8khz_in, manual_error_insert, block_error_insert}, 6'h3F)
        wr(32'h00, 32'h0);
        wr(32'h10, 32'h8200);
        `CHK({ref_8khz_in, manual_error_insert, block_error_insert}, 6'h01)
        finish_test();
    end
endmodule : ppg_top_bench
